// ### rtl/fcpf_pkg.sv
// Package with register map, field widths and factory values
package fcpf_pkg;
  // ============================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] ADDR_PITCH      = 8'h00;
  localparam logic [7:0] ADDR_RESOLUTION = 8'h04;
  localparam logic [7:0] ADDR_DEV_LIMIT  = 8'h08;
  localparam logic [7:0] ADDR_MULT       = 8'h0c;
  localparam logic [7:0] ADDR_USAGE      = 8'h10;
  localparam logic [7:0] ADDR_DIRECTION  = 8'h14;
  localparam logic [7:0] ADDR_MON_SEL    = 8'h18;
  localparam logic [7:0] ADDR_STATUS     = 8'h1c;
  localparam logic [7:0] ADDR_RESTART    = 8'h20;
  // ============================================================
  // Setting ranges and factory values
  localparam logic [20:0] PITCH_MIN    = 21'h000064;
  localparam logic [20:0] PITCH_MAX    = 21'h100000;
  localparam logic [20:0] PITCH_RST    = 21'h008000;
  localparam logic [8:0]  RES_MIN      = 9'h001;
  localparam logic [8:0]  RES_MAX      = 9'h100;
  localparam logic [8:0]  RES_RST      = 9'h014;
  localparam logic [31:0] DEV_MAX      = 32'h40000000;
  localparam logic [31:0] DEV_RST      = 32'h000003e8;
  localparam logic [6:0]  MULT_MIN     = 7'h01;
  localparam logic [6:0]  MULT_MAX     = 7'h64;
  localparam logic [6:0]  MULT_RST     = 7'h14;
  localparam logic [7:0]  MON_POS_ERR  = 8'h07;
  localparam logic [7:0]  MON1_RST     = 8'h02;
  localparam logic [7:0]  MON2_RST     = 8'h00;
  localparam int          SUBPITCH_SH  = 8;
  localparam int          PERCENT      = 100;
  // ============================================================
  // Encoder usage digit
  typedef enum logic [1:0] {FCPF_SEMI, FCPF_FWD, FCPF_REV, FCPF_BAD}
    fcpf_usage_e;
  function automatic fcpf_usage_e fcpf_decode_usage(input logic [3:0] d);
    unique case (d)
      4'h0:    fcpf_decode_usage = FCPF_SEMI;
      4'h1:    fcpf_decode_usage = FCPF_FWD;
      4'h3:    fcpf_decode_usage = FCPF_REV;
      default: fcpf_decode_usage = FCPF_BAD;
    endcase
  endfunction
endpackage

// ### rtl/fcpf_quad_gen.sv
// Quadrature pulse generator that walks an edge count toward a target
`timescale 1ns/100ps
module fcpf_quad_gen
  import fcpf_pkg::*;
#(
  parameter int CW = 32
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic [CW-1:0] target,
  input  wire logic [8:0]    edges_per_pitch,
  output logic               phase_a,
  output logic               phase_b,
  output logic               index
);
  logic [CW-1:0] count_reg;
  logic [8:0]    sub_reg;
  logic          up;
  logic          dn;

  assign up = $signed(target) > $signed(count_reg);
  assign dn = $signed(target) < $signed(count_reg);

  // ============================================================
  // One quadrature edge per clock toward the target
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      sub_reg   <= '0;
    end else if (up) begin
      count_reg <= count_reg + 1'b1;
      sub_reg   <= (sub_reg + 9'h001 >= edges_per_pitch) ? 9'h000
                                                         : sub_reg + 9'h001;
    end else if (dn) begin
      count_reg <= count_reg - 1'b1;
      sub_reg   <= (sub_reg == 9'h000) ? edges_per_pitch - 9'h001
                                       : sub_reg - 9'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_a <= 1'b0;
      phase_b <= 1'b0;
      index   <= 1'b1;
    end else begin
      phase_a <= count_reg[1];
      phase_b <= count_reg[1] ^ count_reg[0];
      index   <= (sub_reg == 9'h000);
    end
  end
endmodule

// ### rtl/fcpf_feedback.sv
// Fully-closed position feedback: divider outputs, deviation alarm
// Operation
// - Pitch count 100..1048576, applied on restart
// - Output resolution 1..256, applied on restart
// - Divide scale position into A, B, index
// - Reversed scale inverts phase B output
// - Alarm when deviation exceeds limit
// - Multiplier 1..100 percent widens deviation check
// - Usage digit 0 semi, 1 forward, 3 reversed
// - Monitor code 07 outputs motor-load error
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module fcpf_feedback
  import fcpf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [31:0] scale_pos,
  input  wire logic [31:0] motor_pos,
  input  wire logic        control_tick,
  input  wire logic        alarm_reset,
  output logic             phase_a_pulse_out,
  output logic             phase_b_pulse_out,
  output logic             index_pulse_out,
  output logic             motor_load_deviation_alarm,
  output logic      [15:0] monitor_one_out,
  output logic      [15:0] monitor_two_out
);
  logic [20:0] pitch_reg;
  logic [20:0] pitch_act_reg;
  logic [8:0]  res_reg;
  logic [8:0]  res_act_reg;
  logic [31:0] dev_limit_reg;
  logic [6:0]  mult_reg;
  logic [3:0]  usage_reg;
  logic [3:0]  direction_reg;
  logic [7:0]  mon1_sel_reg;
  logic [7:0]  mon2_sel_reg;
  logic        restart;
  logic        wr_alarm_clr;
  fcpf_usage_e usage;
  logic        reversed;
  logic        closed;

  // ============================================================
  // Register writes; out-of-range values are ignored
  assign restart      = reg_wr && reg_addr == ADDR_RESTART && reg_wdata[0];
  assign wr_alarm_clr = reg_wr && reg_addr == ADDR_STATUS && reg_wdata[0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pitch_reg     <= PITCH_RST;
      res_reg       <= RES_RST;
      dev_limit_reg <= DEV_RST;
      mult_reg      <= MULT_RST;
      usage_reg     <= 4'h0;
      direction_reg <= 4'h0;
      mon1_sel_reg  <= MON1_RST;
      mon2_sel_reg  <= MON2_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PITCH: begin
          if (reg_wdata >= 32'(PITCH_MIN) && reg_wdata <= 32'(PITCH_MAX))
            pitch_reg <= reg_wdata[20:0];
        end
        ADDR_RESOLUTION: begin
          if (reg_wdata >= 32'(RES_MIN) && reg_wdata <= 32'(RES_MAX))
            res_reg <= reg_wdata[8:0];
        end
        ADDR_DEV_LIMIT: begin
          if (reg_wdata <= DEV_MAX)
            dev_limit_reg <= reg_wdata;
        end
        ADDR_MULT: begin
          if (reg_wdata >= 32'(MULT_MIN) && reg_wdata <= 32'(MULT_MAX))
            mult_reg <= reg_wdata[6:0];
        end
        ADDR_USAGE: begin
          if (fcpf_decode_usage(reg_wdata[3:0]) != FCPF_BAD)
            usage_reg <= reg_wdata[3:0];
        end
        ADDR_DIRECTION: direction_reg <= reg_wdata[3:0];
        ADDR_MON_SEL: begin
          mon1_sel_reg <= reg_wdata[7:0];
          mon2_sel_reg <= reg_wdata[15:8];
        end
        default: ;
      endcase
    end
  end

  // Restart-validated settings take effect only on restart command
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pitch_act_reg <= PITCH_RST;
      res_act_reg   <= RES_RST;
    end else if (restart) begin
      pitch_act_reg <= pitch_reg;
      res_act_reg   <= res_reg;
    end
  end

  assign usage    = fcpf_decode_usage(usage_reg);
  assign reversed = usage == FCPF_REV;
  assign closed   = usage == FCPF_FWD || usage == FCPF_REV;

  // ============================================================
  // Pulse divider
  logic signed [40:0] scaled;
  logic        [31:0] edge_target;
  logic               q_b;

  assign scaled      = $signed(scale_pos) * $signed({32'h0, res_act_reg});
  assign edge_target = scaled[SUBPITCH_SH +: 32];

  fcpf_quad_gen #(.CW(32)) u_quad (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .target          (edge_target),
    .edges_per_pitch (res_act_reg),
    .phase_a         (phase_a_pulse_out),
    .phase_b         (q_b),
    .index           (index_pulse_out)
  );

  assign phase_b_pulse_out = q_b ^ reversed;

  // ============================================================
  // Motor-to-load deviation
  logic signed [32:0] diff;
  logic        [32:0] diff_abs;
  logic        [32:0] limit_eff;
  logic        [27:0] pitch_mult;
  logic               over;

  assign diff       = $signed({scale_pos[31], scale_pos})
                    - $signed({motor_pos[31], motor_pos});
  assign diff_abs   = diff[32] ? 33'(-diff) : 33'(diff);
  assign pitch_mult = 28'(pitch_act_reg) * 28'(mult_reg);
  assign limit_eff  = {1'b0, dev_limit_reg}
                    + 33'(pitch_mult / 28'(PERCENT));
  assign over       = closed && diff_abs > limit_eff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      motor_load_deviation_alarm <= 1'b0;
    end else if (control_tick && over) begin
      motor_load_deviation_alarm <= 1'b1;
    end else if (alarm_reset || wr_alarm_clr) begin
      motor_load_deviation_alarm <= 1'b0;
    end
  end

  // ============================================================
  // Analog monitors, 10 mV per reference unit, saturated
  function automatic logic [15:0] mon_value(input logic [7:0] sel,
                                            input logic signed [32:0] d);
    logic [15:0] v;
    v = 16'h0000;
    if (sel == MON_POS_ERR) begin
      if (d > 33'sd32767)
        v = 16'h7fff;
      else if (d < -33'sd32768)
        v = 16'h8000;
      else
        v = d[15:0];
    end
    mon_value = v;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      monitor_one_out <= 16'h0000;
      monitor_two_out <= 16'h0000;
    end else begin
      monitor_one_out <= mon_value(mon1_sel_reg, diff);
      monitor_two_out <= mon_value(mon2_sel_reg, diff);
    end
  end

  // ============================================================
  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PITCH:      reg_rdata <= 32'(pitch_reg);
        ADDR_RESOLUTION: reg_rdata <= 32'(res_reg);
        ADDR_DEV_LIMIT:  reg_rdata <= dev_limit_reg;
        ADDR_MULT:       reg_rdata <= 32'(mult_reg);
        ADDR_USAGE:      reg_rdata <= 32'(usage_reg);
        ADDR_DIRECTION:  reg_rdata <= 32'(direction_reg);
        ADDR_MON_SEL:    reg_rdata <= {16'h0000, mon2_sel_reg, mon1_sel_reg};
        ADDR_STATUS:     reg_rdata <= {29'h0, reversed, closed,
                                       motor_load_deviation_alarm};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ============================================================
  // Assertions
  property p_pitch_range;
    @(posedge clk_sys) disable iff (!rst_n)
      pitch_reg >= PITCH_MIN && pitch_reg <= PITCH_MAX;
  endproperty
  a_pitch_range: assert property (p_pitch_range)
    else $error("pitch setting out of range");

  property p_restart_apply;
    @(posedge clk_sys) disable iff (!rst_n)
      restart |=> pitch_act_reg == $past(pitch_reg)
               && res_act_reg == $past(res_reg);
  endproperty
  a_restart_apply: assert property (p_restart_apply)
    else $error("restart did not apply settings");

  property p_res_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !restart |=> $stable(res_act_reg);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("resolution changed without restart");

  property p_quad_single;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(phase_a_pulse_out) |-> $stable(q_b);
  endproperty
  a_quad_single: assert property (p_quad_single)
    else $error("both quadrature phases changed together");

  property p_phase_b_rev;
    @(posedge clk_sys) disable iff (!rst_n)
      phase_b_pulse_out == (q_b ^ (usage_reg == 4'h3));
  endproperty
  a_phase_b_rev: assert property (p_phase_b_rev)
    else $error("phase B polarity wrong");

  property p_alarm_set;
    @(posedge clk_sys) disable iff (!rst_n)
      control_tick && closed && diff_abs > limit_eff
        |=> motor_load_deviation_alarm;
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("deviation alarm missed");

  property p_mult_range;
    @(posedge clk_sys) disable iff (!rst_n)
      mult_reg >= MULT_MIN && mult_reg <= MULT_MAX;
  endproperty
  a_mult_range: assert property (p_mult_range)
    else $error("multiplier out of range");

  property p_usage_legal;
    @(posedge clk_sys) disable iff (!rst_n)
      usage_reg == 4'h0 || usage_reg == 4'h1 || usage_reg == 4'h3;
  endproperty
  a_usage_legal: assert property (p_usage_legal)
    else $error("reserved usage digit stored");

  property p_monitor;
    @(posedge clk_sys) disable iff (!rst_n)
      mon1_sel_reg == MON_POS_ERR && diff > -33'sd100 && diff < 33'sd100
        |=> monitor_one_out == $past(diff[15:0]);
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor one does not show position error");

  property p_alarm_sticky;
    @(posedge clk_sys) disable iff (!rst_n)
      motor_load_deviation_alarm && !alarm_reset && !wr_alarm_clr
        |=> motor_load_deviation_alarm;
  endproperty
  a_alarm_sticky: assert property (p_alarm_sticky)
    else $error("alarm dropped without reset");

  c_alarm_rise: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(motor_load_deviation_alarm));
  c_restart: cover property (@(posedge clk_sys) disable iff (!rst_n)
    restart ##1 $changed(res_act_reg));
  c_reversed_pulse: cover property (@(posedge clk_sys) disable iff (!rst_n)
    reversed && $changed(phase_b_pulse_out));
endmodule

// ### test/fcpf_scale_model.sv
// Behavioural external scale seen through the serial converter unit
`timescale 1ns/100ps
module fcpf_scale_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [31:0] goal,
  input  wire logic        slow,
  output logic      [31:0] scale_pos
);
  // ============================================================
  // Position walk: slow steps 1/256 pitch a clock, else jumps
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scale_pos <= 32'h0;
    end else if (!slow || scale_pos == goal) begin
      scale_pos <= goal;
    end else if ($signed(scale_pos) < $signed(goal)) begin
      scale_pos <= scale_pos + 32'h1;
    end else begin
      scale_pos <= scale_pos - 32'h1;
    end
  end
endmodule

// ### test/fcpf_feedback_bench.sv
// Self-checking bench for the fully-closed position feedback block
`timescale 1ns/100ps
module fcpf_feedback_bench
  import fcpf_pkg::*;
;
  // ============================================================
  // Signals
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] scale_pos;
  logic [31:0] motor_pos = 32'h0;
  logic        control_tick = 1'b0;
  logic        alarm_reset = 1'b0;
  logic [31:0] goal = 32'h0;
  logic        slow = 1'b0;
  logic        pa, pb, pi, alarm;
  logic [15:0] mon1, mon2;
  int          failures = 0;
  int          comparisons = 0;

  always #4 clk_sys = ~clk_sys;

  fcpf_feedback uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scale_pos(scale_pos), .motor_pos(motor_pos),
    .control_tick(control_tick), .alarm_reset(alarm_reset),
    .phase_a_pulse_out(pa), .phase_b_pulse_out(pb), .index_pulse_out(pi),
    .motor_load_deviation_alarm(alarm), .monitor_one_out(mon1),
    .monitor_two_out(mon2)
  );

  fcpf_scale_model scale (
    .clk_sys(clk_sys), .rst_n(rst_n), .goal(goal), .slow(slow),
    .scale_pos(scale_pos)
  );

  // ============================================================
  // Shared tasks
  task automatic test_done();
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("read data", exp, reg_rdata);
  endtask

  task automatic tick(input logic [31:0] m, input logic exp);
    @(posedge clk_sys);
    motor_pos <= m;
    @(posedge clk_sys);
    control_tick <= 1'b1;
    @(posedge clk_sys);
    control_tick <= 1'b0;
    @(negedge clk_sys);
    chk("alarm", {31'h0, exp}, {31'h0, alarm});
  endtask

  // Waits up to 400 clocks for A, B, index to match the expected value, then checks them once 30 clocks later
  task automatic pulses(input logic [2:0] exp);
    int n;
    n = 0;
    while ({pa, pb, pi} !== exp && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (30) @(negedge clk_sys);
    chk("pulse outputs", {29'h0, exp}, {29'h0, pa, pb, pi});
    if (n == 400) begin
      failures++;
      test_done();
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic t_defaults();
    rd(ADDR_PITCH, {11'h0, PITCH_RST});
    rd(ADDR_RESOLUTION, {23'h0, RES_RST});
    rd(ADDR_DEV_LIMIT, DEV_RST);
    rd(ADDR_MULT, {25'h0, MULT_RST});
    rd(ADDR_MON_SEL, {16'h0, MON2_RST, MON1_RST});
    rd(ADDR_USAGE, 32'h0);
    rd(8'h24, 32'h0);
  endtask

  task automatic t_refused();
    wr(ADDR_PITCH, 32'h63);
    rd(ADDR_PITCH, {11'h0, PITCH_RST});
    wr(ADDR_PITCH, {11'h0, PITCH_MAX});
    rd(ADDR_PITCH, {11'h0, PITCH_MAX});
    wr(ADDR_PITCH, {11'h0, PITCH_RST});
    wr(ADDR_RESOLUTION, 32'h101);
    rd(ADDR_RESOLUTION, {23'h0, RES_RST});
    wr(ADDR_MULT, 32'h0);
    rd(ADDR_MULT, {25'h0, MULT_RST});
    wr(ADDR_DEV_LIMIT, 32'h40000001);
    rd(ADDR_DEV_LIMIT, DEV_RST);
    wr(ADDR_USAGE, 32'h2);
    rd(ADDR_USAGE, 32'h0);
    wr(ADDR_USAGE, 32'h4);
    rd(ADDR_USAGE, 32'h0);
  endtask

  task automatic t_alarm();
    logic [31:0] thr;
    thr = 32'h64 + {11'h0, PITCH_RST} / 32'h64;
    wr(ADDR_USAGE, 32'h1);
    rd(ADDR_STATUS, 32'h2);
    wr(ADDR_DEV_LIMIT, 32'h64);
    wr(ADDR_MULT, 32'h1);
    tick(32'h0 - thr, 1'b0);
    tick(32'h0 - thr - 32'h1, 1'b1);
    tick(32'h0, 1'b1);
    rd(ADDR_STATUS, 32'h3);
    @(posedge clk_sys);
    alarm_reset <= 1'b1;
    @(posedge clk_sys);
    alarm_reset <= 1'b0;
    @(negedge clk_sys);
    chk("alarm", 32'h0, {31'h0, alarm});
    tick(thr + 32'h1, 1'b1);
    wr(ADDR_STATUS, 32'h1);
    @(negedge clk_sys);
    chk("alarm", 32'h0, {31'h0, alarm});
    @(posedge clk_sys);
    control_tick <= 1'b1;
    alarm_reset <= 1'b1;
    @(posedge clk_sys);
    control_tick <= 1'b0;
    alarm_reset <= 1'b0;
    @(negedge clk_sys);
    chk("alarm set beats clear", 32'h1, {31'h0, alarm});
    wr(ADDR_STATUS, 32'h1);
    @(negedge clk_sys);
    chk("alarm", 32'h0, {31'h0, alarm});
    wr(ADDR_USAGE, 32'h0);
    tick(thr + 32'h1, 1'b0);
  endtask

  task automatic t_monitor();
    wr(ADDR_MON_SEL, 32'h0707);
    motor_pos <= 32'h5;
    repeat (3) @(negedge clk_sys);
    chk("monitor one", 32'hfffb, {16'h0, mon1});
    chk("monitor two", 32'hfffb, {16'h0, mon2});
    @(posedge clk_sys);
    motor_pos <= 32'h00100000;
    repeat (3) @(negedge clk_sys);
    chk("monitor one", 32'h8000, {16'h0, mon1});
    @(posedge clk_sys);
    motor_pos <= 32'hfff00000;
    repeat (3) @(negedge clk_sys);
    chk("monitor one", 32'h7fff, {16'h0, mon1});
    wr(ADDR_MON_SEL, 32'h0);
    repeat (2) @(negedge clk_sys);
    chk("monitor one", 32'h0, {16'h0, mon1});
    chk("monitor two", 32'h0, {16'h0, mon2});
    @(posedge clk_sys);
    motor_pos <= 32'h0;
  endtask

  task automatic t_pulse();
    wr(ADDR_USAGE, 32'h1);
    slow <= 1'b1;
    goal <= 32'hd;
    pulses(3'b010);
    wr(ADDR_RESOLUTION, 32'h4);
    pulses(3'b010);
    wr(ADDR_RESTART, 32'h1);
    pulses(3'b001);
    @(posedge clk_sys);
    goal <= 32'hc0;
    pulses(3'b100);
    wr(ADDR_USAGE, 32'h3);
    wr(ADDR_DIRECTION, 32'h1);
    rd(ADDR_STATUS, 32'h6);
    rd(ADDR_DIRECTION, 32'h1);
    pulses(3'b110);
    wr(ADDR_USAGE, 32'h1);
    pulses(3'b100);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    chk("index in reset", 32'h1, {31'h0, pi});
    rst_n <= 1'b1;
    t_defaults();
    t_refused();
    t_alarm();
    t_monitor();
    t_pulse();
    test_done();
  end
endmodule
